// ==== core/timer_defs.vh ====
// Register indices, field positions, reset values and timing counts for the timer block
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_T0_HIGH      8'h80
`define IDX_CONTROL      8'h88
`define IDX_MODE         8'h89
`define IDX_T0_LOW       8'h8a
`define IDX_T1_LOW       8'h8b
`define IDX_T1_HIGH      8'h8d
`define IDX_AUX          8'ha3

// Reset values
`define RST_BYTE         8'h00

// Control register fields
`define CTL_TF1          7
`define CTL_TR1          6
`define CTL_TF0          5
`define CTL_TR0          4

// Mode register fields
`define MOD_GATE1        7
`define MOD_SRC1         6
`define MOD_M1_HI        5
`define MOD_M1_LO        4
`define MOD_GATE0        3
`define MOD_SRC0         2
`define MOD_M0_HI        1
`define MOD_M0_LO        0

// Mode codes
`define MODE_13BIT       2'h0
`define MODE_16BIT       2'h1
`define MODE_RELOAD      2'h2
`define MODE_SPLIT       2'h3

// Aux register fields
`define AUX_T1_BYPASS    3
`define AUX_T0_BYPASS    2
`define AUX_T1_CKOE      1
`define AUX_T0_CKOE      0

// Prescale of one machine cycle, in system clocks
`define PRESCALE_DIV     12
// Last prescaler state, sized to the four-bit divider
`define PRESCALE_LAST    4'hb

`endif

// ==== core/pin_sampler.v ====
// Two-flop synchroniser with rate-sampled falling edge detector
`timescale 1ns/1ns
module pin_sampler
(
  // Clock and reset
  input  wire core_clk,
  input  wire reset_n,
  // Pin and sampling strobe
  input  wire pin,
  input  wire sample_en,
  // Results
  output wire level,
  output reg  fall
);

  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;

  assign level = sync2_reg;

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      fall      <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      if (sample_en)
        last_reg <= sync2_reg;
      // Registered pulse marks the detection cycle; count lands one cycle later
      fall <= sample_en & last_reg & ~sync2_reg;
    end
  end

endmodule // pin_sampler

// ==== core/dual_timer_counter_clockout.v ====
// Two timer/counters with gating, four modes, clock-out and APB register access
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "timer_defs.vh"
module dual_timer_counter_clockout
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // APB slave
  input  wire [9:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // External pins
  input  wire        event_pin0,
  input  wire        event_pin1,
  input  wire        gate_input_pin0,
  input  wire        gate_input_pin1,
  output reg         timer_zero_clockout_pin,
  output reg         timer_one_clockout_pin,
  // Interrupt controller side
  input  wire        vector_ack0,
  input  wire        vector_ack1,
  output reg         timer0_irq,
  output reg         timer1_irq,
  // Serial port side
  output reg         baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Count step: returns {overflow, high byte, low byte}

  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] high;
    input [7:0] low;
    reg   [13:0] s13;
    reg   [16:0] s16;
    begin
      s13 = {1'b0, high, low[4:0]} + 14'h0001;
      s16 = {1'b0, high, low} + 17'h00001;
      case (mode)
        `MODE_13BIT:
          count_step = {s13[13], s13[12:5], low[7:5], s13[4:0]};
        `MODE_16BIT:
          count_step = s16;
        `MODE_RELOAD:
          count_step = {(low == 8'hff), high,
                        (low == 8'hff) ? high : low + 8'h01};
        default:
          count_step = {(low == 8'hff), high, low + 8'h01};
      endcase
    end
  endfunction

  // Register index match
  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0] th0_reg;
  reg  [7:0] tl0_reg;
  reg  [7:0] th1_reg;
  reg  [7:0] tl1_reg;
  reg  [7:0] mode_reg;
  reg  [7:0] aux_reg;
  reg        tf0_reg;
  reg        tf1_reg;
  reg        tr0_reg;
  reg        tr1_reg;
  reg  [3:0] div_reg;

  reg  [7:0] th0_next;
  reg  [7:0] tl0_next;
  reg  [7:0] th1_next;
  reg  [7:0] tl1_next;
  reg        tf0_next;
  reg        tf1_next;

  wire       tick12;
  wire       rate0;
  wire       rate1;
  wire       gate0_lvl;
  wire       gate1_lvl;
  wire       fall0;
  wire       fall1;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: one pulse per machine cycle

  assign tick12 = (div_reg == `PRESCALE_LAST);

  always @(posedge core_clk)
  begin
    if (!reset_n)
      div_reg <= 4'h0;
    else if (tick12)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  // Bypass applies to the internal clock only; event pins sample per machine cycle
  assign rate0 = aux_reg[`AUX_T0_BYPASS] ? 1'b1 : tick12;
  assign rate1 = aux_reg[`AUX_T1_BYPASS] ? 1'b1 : tick12;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  pin_sampler u_event0
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin       (event_pin0),
    .sample_en (tick12),
    .level     (),
    .fall      (fall0)
  );

  pin_sampler u_event1
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin       (event_pin1),
    .sample_en (tick12),
    .level     (),
    .fall      (fall1)
  );

  pin_sampler u_gate0
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin       (gate_input_pin0),
    .sample_en (1'b0),
    .level     (gate0_lvl),
    .fall      ()
  );

  pin_sampler u_gate1
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin       (gate_input_pin1),
    .sample_en (1'b0),
    .level     (gate1_lvl),
    .fall      ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and count enables

  wire [1:0]  m0      = mode_reg[`MOD_M0_HI:`MOD_M0_LO];
  wire [1:0]  m1      = mode_reg[`MOD_M1_HI:`MOD_M1_LO];
  wire        src0    = mode_reg[`MOD_SRC0];
  wire        src1    = mode_reg[`MOD_SRC1];
  wire        cko0    = ~src0 & aux_reg[`AUX_T0_CKOE];
  wire        cko1    = ~src1 & aux_reg[`AUX_T1_CKOE];
  wire        split   = (m0 == `MODE_SPLIT) & ~cko0;
  wire [1:0]  em0     = cko0 ? `MODE_RELOAD : m0;
  wire [1:0]  em1     = cko1 ? `MODE_RELOAD : m1;

  wire        run0    = tr0_reg & (~mode_reg[`MOD_GATE0] | gate0_lvl);
  wire        run1    = tr1_reg & (~mode_reg[`MOD_GATE1] | gate1_lvl)
                        & ((m1 != `MODE_SPLIT) | cko1);
  wire        inc0    = run0 & (src0 ? fall0 : rate0);
  wire        inc1    = run1 & (src1 ? fall1 : rate1);
  // Split high byte counts the internal clock only, under timer one's run bit
  wire        inc0h   = split & tr1_reg & rate0;

  wire [16:0] step0   = count_step(em0, th0_reg, tl0_reg);
  wire [16:0] step1   = count_step(em1, th1_reg, tl1_reg);
  wire        ovf0    = inc0 & step0[16];
  wire        ovf1    = inc1 & step1[16];
  wire        ovf0h   = inc0h & (th0_reg == 8'hff);

  ////////////////////////////////////////////////////////////////////////////
  // APB access

  wire        wr_en   = psel & penable & pwrite & pstrb[0];
  wire        setup   = psel & ~penable;
  wire        mapped  = hit(paddr, `IDX_T0_HIGH) | hit(paddr, `IDX_CONTROL) |
                        hit(paddr, `IDX_MODE) | hit(paddr, `IDX_T0_LOW) |
                        hit(paddr, `IDX_T1_LOW) | hit(paddr, `IDX_T1_HIGH) |
                        hit(paddr, `IDX_AUX);
  wire        wr_th0  = wr_en & hit(paddr, `IDX_T0_HIGH);
  wire        wr_tl0  = wr_en & hit(paddr, `IDX_T0_LOW);
  wire        wr_th1  = wr_en & hit(paddr, `IDX_T1_HIGH);
  wire        wr_tl1  = wr_en & hit(paddr, `IDX_T1_LOW);
  wire        wr_ctl  = wr_en & hit(paddr, `IDX_CONTROL);
  wire        wr_mod  = wr_en & hit(paddr, `IDX_MODE);
  wire        wr_aux  = wr_en & hit(paddr, `IDX_AUX);

  // Zero wait states: the answer is prepared in the setup cycle
  assign pready = 1'b1;

  reg  [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if (hit(paddr, `IDX_T0_HIGH))
      rd_byte = th0_reg;
    else if (hit(paddr, `IDX_T0_LOW))
      rd_byte = tl0_reg;
    else if (hit(paddr, `IDX_T1_HIGH))
      rd_byte = th1_reg;
    else if (hit(paddr, `IDX_T1_LOW))
      rd_byte = tl1_reg;
    else if (hit(paddr, `IDX_MODE))
      rd_byte = mode_reg;
    else if (hit(paddr, `IDX_AUX))
      rd_byte = aux_reg;
    else if (hit(paddr, `IDX_CONTROL))
      rd_byte = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state of counts and flags

  always @*
  begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    tl1_next = tl1_reg;
    th1_next = th1_reg;
    tf0_next = tf0_reg;
    tf1_next = tf1_reg;

    if (inc0)
    begin
      tl0_next = step0[7:0];
      th0_next = step0[15:8];
    end
    if (inc0h)
      th0_next = th0_reg + 8'h01;
    if (inc1)
    begin
      tl1_next = step1[7:0];
      th1_next = step1[15:8];
    end

    // A software write to a count byte wins over the hardware step
    if (wr_tl0)
      tl0_next = pwdata[7:0];
    if (wr_th0)
      th0_next = pwdata[7:0];
    if (wr_tl1)
      tl1_next = pwdata[7:0];
    if (wr_th1)
      th1_next = pwdata[7:0];

    // Clears first, then hardware sets so a same-cycle overflow is kept
    if (vector_ack0)
      tf0_next = 1'b0;
    if (vector_ack1)
      tf1_next = 1'b0;
    if (wr_ctl)
    begin
      tf0_next = pwdata[`CTL_TF0];
      tf1_next = pwdata[`CTL_TF1];
    end
    if (ovf0)
      tf0_next = 1'b1;
    if (ovf1 | ovf0h)
      tf1_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      th0_reg  <= `RST_BYTE;
      tl0_reg  <= `RST_BYTE;
      th1_reg  <= `RST_BYTE;
      tl1_reg  <= `RST_BYTE;
      mode_reg <= `RST_BYTE;
      aux_reg  <= `RST_BYTE;
      tf0_reg  <= 1'b0;
      tf1_reg  <= 1'b0;
      tr0_reg  <= 1'b0;
      tr1_reg  <= 1'b0;
    end
    else
    begin
      th0_reg <= th0_next;
      tl0_reg <= tl0_next;
      th1_reg <= th1_next;
      tl1_reg <= tl1_next;
      tf0_reg <= tf0_next;
      tf1_reg <= tf1_next;
      if (wr_ctl)
      begin
        tr0_reg <= pwdata[`CTL_TR0];
        tr1_reg <= pwdata[`CTL_TR1];
      end
      if (wr_mod)
        mode_reg <= pwdata[7:0];
      if (wr_aux)
        aux_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data and error, captured in the setup cycle

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= {24'h000000, rd_byte};
      pslverr <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock-out, interrupt requests and baud tick

  // Toggling on every overflow halves the overflow rate, giving n of 24 or 2
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      timer_zero_clockout_pin <= 1'b0;
      timer_one_clockout_pin  <= 1'b0;
      timer0_irq              <= 1'b0;
      timer1_irq              <= 1'b0;
      baud_tick               <= 1'b0;
    end
    else
    begin
      if (!cko0)
        timer_zero_clockout_pin <= 1'b0;
      else if (ovf0)
        timer_zero_clockout_pin <= ~timer_zero_clockout_pin;
      if (!cko1)
        timer_one_clockout_pin <= 1'b0;
      else if (ovf1)
        timer_one_clockout_pin <= ~timer_one_clockout_pin;
      // Flags still set in clock-out mode but are kept off the request lines
      timer0_irq <= tf0_next & ~cko0;
      timer1_irq <= tf1_next & ~cko1;
      baud_tick  <= ovf1;
    end
  end

endmodule // dual_timer_counter_clockout

// ==== test/dual_timer_counter_clockout_sva.sv ====
// Port-level checks for the dual timer block
`timescale 1ns/1ns
module dual_timer_counter_clockout_sva
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // APB slave
  input wire logic [9:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Clock-out pins and interrupts
  input wire logic        timer_zero_clockout_pin,
  input wire logic        timer_one_clockout_pin,
  input wire logic        timer0_irq,
  input wire logic        timer1_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire setup  = psel && !penable;
  wire mapped = paddr[9:2] inside {8'h80, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8d, 8'ha3};
  ////////////////////////////////////////////////////////////
  a_pready_high: assert property (pready) else $error("pready low");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_err_unmapped: assert property (setup && paddr[1:0] == 2'h0 && !mapped
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && paddr[1:0] == 2'h0 && mapped |=> !pslverr)
    else $error("mapped refused");
  // Answers stand until the next setup so a slow master still reads them
  a_rdata_stand: assert property (!setup |=> $stable(prdata)) else $error("prdata moved");
  a_err_stand: assert property (!setup |=> $stable(pslverr)) else $error("pslverr moved");
  a_clkout0_noirq: assert property ($rose(timer_zero_clockout_pin) |-> !timer0_irq)
    else $error("clock-out timer zero raised irq");
  a_clkout1_noirq: assert property ($rose(timer_one_clockout_pin) |-> !timer1_irq)
    else $error("clock-out timer one raised irq");
endmodule // dual_timer_counter_clockout_sva

// ==== test/pin_partner.sv ====
// Far-side pin model: event source, gate level, clock-out period meter
`timescale 1ns/1ns
module pin_partner
(
  // Clock
  input wire logic core_clk,
  // Pins driven toward the block
  output logic     event_pin0,
  output logic     gate_input_pin0,
  // Pins watched from the block
  input wire logic timer_zero_clockout_pin,
  input wire logic timer_one_clockout_pin,
  input wire logic baud_tick
);
  int   cnt0 = 0, cnt1 = 0, period0 = 0, period1 = 0, baud_n = 0;
  logic last0 = 1'b0, last1 = 1'b0;
  // Gate held low so the bench can freeze a gated timer
  initial
  begin
    event_pin0 = 1'b1;
    gate_input_pin0 = 1'b0;
  end
  // Each level lasts longer than two machine cycles so no sample misses it
  task automatic make_falls(input int k);
    repeat (k)
    begin
      @(posedge core_clk) event_pin0 <= 1'b0;
      repeat (30) @(posedge core_clk);
      event_pin0 <= 1'b1;
      repeat (30) @(posedge core_clk);
    end
  endtask
  // Gate level changes just after an edge, like any other pin stimulus
  task automatic set_gate(input logic v);
    @(posedge core_clk) gate_input_pin0 <= v;
  endtask
  always @(posedge core_clk)
  begin
    last0 <= timer_zero_clockout_pin;
    last1 <= timer_one_clockout_pin;
    cnt0 <= (timer_zero_clockout_pin && !last0) ? 1 : cnt0 + 1;
    cnt1 <= (timer_one_clockout_pin && !last1) ? 1 : cnt1 + 1;
    if (timer_zero_clockout_pin && !last0) period0 <= cnt0;
    if (timer_one_clockout_pin && !last1) period1 <= cnt1;
    if (baud_tick) baud_n <= baud_n + 1;
  end
endmodule // pin_partner

// ==== test/dual_timer_counter_clockout_tb.sv ====
// Self-checking bench for the dual timer block
`timescale 1ns/1ns
`include "timer_defs.vh"
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
      begin \
      n_mismatch++; \
      $display("ERROR %0t: got %0h expected %0h", $time, g, e); \
    end \
  end
module dual_timer_counter_clockout_tb;
  logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        vector_ack0 = 0, vector_ack1 = 0, e1;
  logic [9:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0]  pstrb = 4'hf;
  wire         pready, pslverr, timer_zero_clockout_pin, timer_one_clockout_pin;
  wire         timer0_irq, timer1_irq, baud_tick, event_pin0, gate_input_pin0;
  wire  [31:0] prdata;
  logic [7:0]  r8, th, tl, rv;
  logic [16:0] x;
  int          n_mismatch = 0, checks_done = 0, n, k, b;
  logic [7:0]  regs [7] = '{`IDX_T0_HIGH, `IDX_CONTROL, `IDX_MODE, `IDX_T0_LOW,
                            `IDX_T1_LOW, `IDX_T1_HIGH, `IDX_AUX};
  always #4 core_clk = ~core_clk;
  dual_timer_counter_clockout u_dual_timer_counter_clockout
  (.core_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready,
   .prdata, .pslverr, .event_pin0, .event_pin1(1'b1), .gate_input_pin0,
   .gate_input_pin1(1'b0), .timer_zero_clockout_pin, .timer_one_clockout_pin,
   .vector_ack0, .vector_ack1, .timer0_irq, .timer1_irq, .baud_tick);
  pin_partner u_pins
  (.core_clk, .event_pin0, .gate_input_pin0, .timer_zero_clockout_pin,
   .timer_one_clockout_pin, .baud_tick);
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, wd,
                     output logic [7:0] rd, output logic err);
    int t;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (pready !== 1'b1 && t < 16);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    apb(1'b1, i, d, r8, e1);
  endtask
  task automatic rc(input logic [7:0] i, e);
    apb(1'b0, i, 8'h00, r8, e1);
    `CHK(r8, e)
  endtask
  // Timer zero runs n + 3 cycles after its start, then is frozen by gating on a low gate pin
  task automatic run0(input logic [7:0] md, aux, h, l, input int n);
    wr(`IDX_MODE, md);
    wr(`IDX_AUX, aux);
    wr(`IDX_T0_HIGH, h);
    wr(`IDX_T0_LOW, l);
    wr(`IDX_CONTROL, 8'h10);
    repeat (n) @(posedge core_clk);
    wr(`IDX_MODE, md | 8'h08);
  endtask
  // Count and flag after k steps in modes zero to two
  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] c, input int k);
    logic        f, o;
    logic [12:0] v;
    f = 1'b0;
    repeat (k)
    begin
      v = {c[15:8], c[4:0]} + 13'h1;
      o = (m == 2'h0) ? v == 13'h0 : (m == 2'h1) ? c == 16'hffff : c[7:0] == 8'hff;
      f = f | o;
      if (m == 2'h0) c = {v[12:5], c[7:5], v[4:0]};
      if (m == 2'h1) c = c + 16'h1;
      if (m == 2'h2) c[7:0] = o ? c[15:8] : c[7:0] + 8'h1;
    end
    return {f, c};
  endfunction
  ////////////////////////////////////////////////////////////
  initial
  begin
    r8 = $urandom(68);
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (regs[i]) rc(regs[i], 8'h00);
    foreach (regs[i])
      if (regs[i] != `IDX_CONTROL)
      begin
        rv = $urandom;
        wr(regs[i], rv);
        rc(regs[i], rv);
      end
    wr(`IDX_AUX, 8'h00);
    wr(`IDX_MODE, 8'h00);
    wr(`IDX_CONTROL, 8'haf);
    rc(`IDX_CONTROL, 8'ha0);
    `CHK(timer0_irq & timer1_irq, 1'b1)
    @(posedge core_clk) vector_ack0 <= 1'b1;
    @(posedge core_clk) vector_ack0 <= 1'b0;
    rc(`IDX_CONTROL, 8'h80);
    @(posedge core_clk) vector_ack1 <= 1'b1;
    @(posedge core_clk) vector_ack1 <= 1'b0;
    rc(`IDX_CONTROL, 8'h00);
    apb(1'b0, 8'h90, 8'h00, r8, e1);
    `CHK({e1, r8}, 9'h100)
    for (int m = 0; m < 3; m++)
    begin
      th = (m == 2) ? $urandom : 8'hff;
      tl = $urandom | 8'hfc;
      n = $urandom_range(6);
      x = step(m[1:0], {th, tl}, n + 3);
      run0({6'h0, m[1:0]}, 8'h04, th, tl, n);
      rc(`IDX_T0_LOW, x[7:0]);
      rc(`IDX_T0_HIGH, x[15:8]);
      `CHK(timer0_irq, x[16])
      rc(`IDX_CONTROL, {2'b00, x[16], 5'h10});
      wr(`IDX_CONTROL, 8'h00);
    end
    run0(8'h01, 8'h00, 8'h00, 8'h00, 117);
    apb(1'b0, `IDX_T0_LOW, 8'h00, r8, e1);
    `CHK(r8, (117 + 3) / `PRESCALE_DIV)
    k = $urandom_range(1, 4);
    wr(`IDX_MODE, 8'h05);
    wr(`IDX_T0_LOW, 8'h00);
    wr(`IDX_CONTROL, 8'h10);
    u_pins.make_falls(k);
    repeat (40) @(posedge core_clk);
    wr(`IDX_MODE, 8'h0d);
    rc(`IDX_T0_LOW, k[7:0]);
    wr(`IDX_T1_LOW, 8'h55);
    wr(`IDX_MODE, 8'h30);
    wr(`IDX_AUX, 8'h08);
    wr(`IDX_CONTROL, 8'h40);
    repeat (30) @(posedge core_clk);
    rc(`IDX_T1_LOW, 8'h55);
    wr(`IDX_CONTROL, 8'h00);
    rv = 8'hf0 | $urandom_range(14);
    wr(`IDX_AUX, 8'h05);
    wr(`IDX_MODE, 8'h00);
    wr(`IDX_T0_HIGH, rv);
    wr(`IDX_T0_LOW, rv);
    wr(`IDX_CONTROL, 8'h10);
    repeat (8 * (256 - rv) + 8) @(posedge core_clk);
    `CHK(u_pins.period0, 2 * (256 - rv))
    `CHK({timer0_irq, timer_one_clockout_pin}, 2'b00)
    rc(`IDX_CONTROL, 8'h30);
    wr(`IDX_CONTROL, 8'h00);
    wr(`IDX_AUX, 8'h02);
    wr(`IDX_T1_HIGH, 8'hfe);
    wr(`IDX_T1_LOW, 8'hfe);
    wr(`IDX_CONTROL, 8'h40);
    repeat (150) @(posedge core_clk);
    b = u_pins.baud_n;
    repeat (96) @(posedge core_clk);
    `CHK(u_pins.baud_n - b, 4)
    `CHK(u_pins.period1, 48)
    // Split timer zero: both bytes step every cycle, high byte under timer one's run bit
    wr(`IDX_CONTROL, 8'h00);
    th = $urandom | 8'hf8;
    tl = $urandom | 8'hf0;
    n = $urandom_range(6);
    wr(`IDX_MODE, 8'h33);
    wr(`IDX_AUX, 8'h04);
    wr(`IDX_T0_HIGH, th);
    wr(`IDX_T0_LOW, tl);
    wr(`IDX_CONTROL, 8'h50);
    repeat (n) @(posedge core_clk);
    wr(`IDX_MODE, 8'h38);
    rc(`IDX_T0_LOW, tl + 8'(n + 3));
    rc(`IDX_T0_HIGH, th + 8'(n + 3));
    `CHK(timer1_irq, th + n + 3 > 255)
    rc(`IDX_CONTROL, {th + n + 3 > 255, 1'b1, tl + n + 3 > 255, 5'h10});
    // Gated timer counts only while the synchronised gate pin stands high
    wr(`IDX_MODE, 8'h09);
    wr(`IDX_AUX, 8'h04);
    wr(`IDX_T0_LOW, 8'h00);
    wr(`IDX_CONTROL, 8'h10);
    u_pins.set_gate(1'b1);
    repeat (20) @(posedge core_clk);
    u_pins.set_gate(1'b0);
    repeat (4) @(posedge core_clk);
    rc(`IDX_T0_LOW, 8'd21);
    report_and_stop();
  end
endmodule // dual_timer_counter_clockout_tb
bind dual_timer_counter_clockout dual_timer_counter_clockout_sva u_sva
(.core_clk, .reset_n, .paddr, .psel, .penable, .pready, .prdata, .pslverr,
 .timer_zero_clockout_pin, .timer_one_clockout_pin, .timer0_irq, .timer1_irq);
